// >>> shared/sspc_pkg.sv
// Purpose: Shared constants and types of the speed setpoint channel
// Assumes: 16-bit speed words in rpm, scaling words in Q2.14
// Notes: Source selector codes name connectors and binector bits
package sspc_pkg;
  localparam int RX_WORDS = 12;
  localparam int FIX_WORDS = 4;
  localparam int SCALE_SHIFT = 14;
  localparam logic signed [15:0] SCALE_ONE = 16'sh4000;
  // Word source codes
  localparam logic [7:0] SRC_ZERO = 8'h00;
  localparam logic [7:0] SRC_ONE = 8'h01;
  localparam logic [7:0] SRC_RX_BASE = 8'h10;
  localparam logic [7:0] SRC_POT = 8'h20;
  localparam logic [7:0] SRC_FIX_BASE = 8'h30;
  localparam logic [7:0] SRC_ANALOG = 8'h40;
  // Bit source codes: control word bit n is BSRC_CW_BASE + n
  localparam logic [7:0] BSRC_CW_BASE = 8'h20;
  // Reset values
  localparam logic [7:0] RST_MAIN_SRC_FB = 8'h11;
  localparam logic [7:0] RST_MAIN_SRC_NOFB = 8'h40;
  localparam logic [7:0] RST_MSCALE_SRC = 8'h01;
  localparam logic [7:0] RST_SUPP_SRC = 8'h00;
  localparam logic [7:0] RST_SSCALE_SRC = 8'h00;
  localparam logic [7:0] RST_RAISE_FB = 8'h2d;
  localparam logic [7:0] RST_LOWER_FB = 8'h2e;
  localparam logic [7:0] RST_BIN_ZERO = 8'h00;
  localparam logic signed [15:0] RST_START = 16'sh0000;
  localparam logic signed [15:0] RST_POT_LIMIT = 16'sh0000;
  localparam logic signed [15:0] RST_REF_MAX = 16'sh03e8;
  localparam logic signed [15:0] RST_FIXED = 16'sh0000;
  localparam int RAMP_DEFAULT_S = 10;
  localparam logic [15:0] RST_RAMP_MS = 16'(RAMP_DEFAULT_S * 1000);
  localparam logic [4:0] RST_POT_CFG = 5'h06;
  localparam int CFG_STORE = 0;
  localparam int CFG_ALWAYS = 4;
  // Register byte offsets
  localparam logic [7:0] A_MAIN_SRC = 8'h00;
  localparam logic [7:0] A_MSCALE_SRC = 8'h04;
  localparam logic [7:0] A_SUPP_SRC = 8'h08;
  localparam logic [7:0] A_SSCALE_SRC = 8'h0c;
  localparam logic [7:0] A_RAISE_SRC = 8'h10;
  localparam logic [7:0] A_LOWER_SRC = 8'h14;
  localparam logic [7:0] A_ACCEPT_SRC = 8'h18;
  localparam logic [7:0] A_SETVAL_SRC = 8'h1c;
  localparam logic [7:0] A_START = 8'h20;
  localparam logic [7:0] A_RISE_MS = 8'h24;
  localparam logic [7:0] A_FALL_MS = 8'h28;
  localparam logic [7:0] A_MAX = 8'h2c;
  localparam logic [7:0] A_MIN = 8'h30;
  localparam logic [7:0] A_CFG = 8'h34;
  localparam logic [7:0] A_REF_MAX = 8'h38;
  localparam logic [7:0] A_FIX_BASE = 8'h40;
  localparam logic [7:0] A_ACTIVE_MAIN = 8'h50;
  localparam logic [7:0] A_POT_OUT = 8'h54;
  localparam logic [7:0] A_TOTAL = 8'h58;
  localparam logic [7:0] A_RX_BASE = 8'h80;
  localparam logic [2:0] SIZE_WORD = 3'h2;
  // Ramp tick timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK_TIME_NS = 1000000;
  localparam int TICK_CYCLES_DEF = TICK_TIME_NS / CLK_PERIOD_NS;
  typedef enum logic [1:0] {POT_HOLD, POT_UP, POT_DOWN} sspc_pot_dir_t;
endpackage

// >>> shared/sspc_pot_if.sv
// Purpose: Carrier between setpoint channel and potentiometer
// Assumes: One clock domain
// Notes: Channel drives settings, potentiometer returns its value
`timescale 1ns/1ps
interface sspc_pot_if;
  logic signed [15:0] startValue;
  logic signed [15:0] maxSpeed;
  logic signed [15:0] minSpeed;
  logic signed [15:0] setValue;
  logic signed [15:0] refMax;
  logic signed [15:0] outValue;
  logic [15:0] riseMs;
  logic [15:0] fallMs;
  logic [4:0] cfg;
  logic raise;
  logic lower;
  logic accept;
  logic motorOn;
  logic msTick;
  modport ctrl (output startValue, maxSpeed, minSpeed, setValue, refMax, riseMs, fallMs,
    cfg, raise, lower, accept, motorOn, msTick, input outValue);
  modport pot (input startValue, maxSpeed, minSpeed, setValue, refMax, riseMs, fallMs,
    cfg, raise, lower, accept, motorOn, msTick, output outValue);
endinterface

// >>> core/sspc_pot.sv
// Purpose: Motorized potentiometer with ramp and limits
// Assumes: msTick pulses once per millisecond
// Notes: At most one rpm step per tick, except a zero ramp time jumps straight to the limit
`timescale 1ns/1ps
module sspc_pot
  import sspc_pkg::*;
(
  input wire logic clk, // Control clock
  input wire logic arst_n, // Async reset, active low
  sspc_pot_if.pot bus // Settings in, value out
);
  logic signed [15:0] value;
  logic signed [15:0] saved;
  logic [16:0] acc;
  logic acceptPrev;
  logic motorPrev;
  logic signed [15:0] next_value;
  logic [16:0] next_acc;
  logic [16:0] sum;
  logic [16:0] span;

  function automatic logic signed [15:0] clampSpeed(input logic signed [15:0] v,
    input logic signed [15:0] lo, input logic signed [15:0] hi);
    if (v > hi)
      return hi;
    else if (v < lo)
      return lo;
    return v;
  endfunction

  wire acceptRise = bus.accept && !acceptPrev;
  wire motorRise = bus.motorOn && !motorPrev;
  wire motorFall = !bus.motorOn && motorPrev;
  wire rampOn = bus.motorOn || bus.cfg[CFG_ALWAYS];
  wire sspc_pot_dir_t dir = (bus.raise && !bus.lower) ? POT_UP :
    (bus.lower && !bus.raise) ? POT_DOWN : POT_HOLD;
  assign bus.outValue = value;

  ////////////////////////////////////////////////////////////////
  // Ramp step and load priority
  always_comb
  begin
    next_acc = acc;
    next_value = value;
    span = (dir == POT_UP) ? {1'b0, bus.riseMs} : {1'b0, bus.fallMs};
    sum = acc + {1'b0, bus.refMax};
    case (dir)
      POT_UP, POT_DOWN:
      begin
        if (rampOn && bus.msTick)
        begin
          if (span == 17'h0)
            next_value = (dir == POT_UP) ? bus.maxSpeed : bus.minSpeed;
          else if (sum >= span)
          begin
            next_acc = (sum - span >= span) ? 17'h0 : sum - span;
            if (dir == POT_UP && value < bus.maxSpeed)
              next_value = value + 16'sh0001;
            else if (dir == POT_DOWN && value > bus.minSpeed)
              next_value = value - 16'sh0001;
          end
          else
            next_acc = sum;
        end
      end
      POT_HOLD: next_acc = 17'h0;
      default: next_acc = 17'h0;
    endcase
    if (motorRise)
      next_value = bus.cfg[CFG_STORE] ? saved : bus.startValue;
    else if (acceptRise)
      next_value = bus.setValue;
    next_value = clampSpeed(next_value, bus.minSpeed, bus.maxSpeed);
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      value <= RST_START;
      saved <= RST_START;
      acc <= 17'h0;
      acceptPrev <= 1'b0;
      motorPrev <= 1'b0;
    end
    else
    begin
      value <= next_value;
      acc <= next_acc;
      acceptPrev <= bus.accept;
      motorPrev <= bus.motorOn;
      if (motorFall && bus.cfg[CFG_STORE])
        saved <= value;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence upTick;
    dir == POT_UP && bus.msTick && rampOn && !acceptRise && !motorRise;
  endsequence
  sequence downTick;
    dir == POT_DOWN && bus.msTick && rampOn && !acceptRise && !motorRise;
  endsequence
  sequence steadyLimits;
    $stable(bus.maxSpeed) && $stable(bus.minSpeed) && bus.minSpeed <= bus.maxSpeed;
  endsequence
  chk_pot_clamp: assert property (bus.minSpeed <= bus.maxSpeed |=>
    value <= $past(bus.maxSpeed) && value >= $past(bus.minSpeed))
    else $error("pot value outside limits");
  chk_pot_raise: assert property (upTick and steadyLimits and
    (value >= bus.minSpeed) and (bus.riseMs != 16'h0) |=>
    value == $past(value) || value == $past(value) + 16'sh0001)
    else $error("pot raise step wrong");
  chk_pot_lower: assert property (downTick and steadyLimits and
    (value <= bus.maxSpeed) and (bus.fallMs != 16'h0) |=>
    value == $past(value) || value == $past(value) - 16'sh0001)
    else $error("pot lower step wrong");
  chk_pot_start: assert property (motorRise && !bus.cfg[CFG_STORE] |=>
    value == clampSpeed($past(bus.startValue), $past(bus.minSpeed), $past(bus.maxSpeed)))
    else $error("pot start value not loaded");
  chk_pot_restore: assert property (motorRise && bus.cfg[CFG_STORE] |=>
    value == clampSpeed($past(saved), $past(bus.minSpeed), $past(bus.maxSpeed)))
    else $error("pot stored value not restored");
  chk_pot_accept: assert property (acceptRise && !motorRise |=>
    value == clampSpeed($past(bus.setValue), $past(bus.minSpeed), $past(bus.maxSpeed)))
    else $error("pot setting value not taken");
endmodule

// >>> core/sspc_channel.sv
// Purpose: Speed setpoint channel with source selection and potentiometer
// Assumes: AHB-Lite single slave, word access only, same-clock fieldbus
// Notes: Reads take one wait state, writes none
//
// Notes on behaviour
// - Positioner active forces total setpoint zero
// - Main and supplementary sources are selectable
// - Jog or panel control substitutes alternative setpoint
// - Main source defaults depend on fieldbus presence
// - Code for word one takes second word
// - Main scaling source defaults to one
// - Active main setpoint readable
// - Supplementary source defaults to zero
// - Supplementary scaling source defaults to zero
// - Every received word is readable
// - Potentiometer moves with raise and lower
// - Raise command increases output continuously
// - Lower command decreases output continuously
// - Switch-on loads configured start value
// - Raising uses rise time, default ten seconds
// - Lowering uses fall time, default ten seconds
// - Potentiometer output is a selectable connector
// - Output clamped between minimum and maximum speed
// - Accept edge takes the setting value
// - Config bit zero stores and restores setpoint
//
// Added by the designer: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module sspc_channel
  import sspc_pkg::*;
#(
  parameter bit HAS_FIELDBUS = 1'b1, // Unit carries a fieldbus
  parameter int TICK_CYCLES = TICK_CYCLES_DEF // Cycles per ramp tick
)
(
  input wire logic clk, // Control clock
  input wire logic arst_n, // Async reset, active low
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write request
  input wire logic [2:0] hsize, // Transfer size
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  output logic [31:0] hrdata, // Read data
  output logic hreadyout, // Slave ready
  output logic hresp, // Always OKAY
  input wire logic [RX_WORDS*16-1:0] fieldbusReceiveWords, // Received words
  input wire logic [15:0] fieldbusControlWordBits, // Received control word
  input wire logic signed [15:0] analogIn, // Analog input connector
  input wire logic signed [15:0] altSetpoint, // Jog or panel setpoint
  input wire logic jogActive, // Jogging active
  input wire logic panelControl, // Panel or PC tool in control
  input wire logic positionerActive, // Basic positioner in use
  input wire logic motorOn, // Motor switched on
  output logic signed [15:0] totalSetpoint, // Total speed setpoint
  output logic signed [15:0] activeMainSetpoint, // Main after selection
  output logic signed [15:0] potRampedOutput // Potentiometer output
);
  logic [7:0] mainSrc;
  logic [7:0] mainScaleSrc;
  logic [7:0] suppSrc;
  logic [7:0] suppScaleSrc;
  logic [7:0] raiseSrc;
  logic [7:0] lowerSrc;
  logic [7:0] acceptSrc;
  logic [7:0] setValSrc;
  logic signed [15:0] startValue;
  logic signed [15:0] maxSpeed;
  logic signed [15:0] minSpeed;
  logic signed [15:0] refMax;
  logic [15:0] riseMs;
  logic [15:0] fallMs;
  logic [4:0] potCfg;
  logic signed [15:0] fixedSp [FIX_WORDS];
  logic wrPend;
  logic rdPend;
  logic [7:0] wrAddr;
  logic [7:0] rdAddr;
  logic [15:0] tickCnt;
  logic msTick;
  logic [31:0] rdValue;

  sspc_pot_if potBus();

  sspc_pot u_pot (
    .clk(clk),
    .arst_n(arst_n),
    .bus(potBus.pot)
  );

  ////////////////////////////////////////////////////////////////
  // Connector selection
  function automatic logic signed [15:0] pickWord(input logic [7:0] sel);
    logic [3:0] idx;
    idx = sel[3:0];
    if (sel == SRC_ZERO)
      return 16'sh0000;
    else if (sel == SRC_ONE)
      return SCALE_ONE;
    else if (sel == SRC_POT)
      return potBus.outValue;
    else if (sel == SRC_ANALOG)
      return analogIn;
    else if (sel[7:4] == SRC_RX_BASE[7:4] && int'(idx) < RX_WORDS)
      return fieldbusReceiveWords[int'(idx)*16 +: 16];
    else if (sel[7:4] == SRC_FIX_BASE[7:4] && int'(idx) < FIX_WORDS)
      return fixedSp[int'(idx)];
    return 16'sh0000;
  endfunction

  function automatic logic pickBit(input logic [7:0] sel);
    if (sel == SRC_ONE)
      return 1'b1;
    else if (sel[7:4] == BSRC_CW_BASE[7:4])
      return fieldbusControlWordBits[sel[3:0]];
    return 1'b0;
  endfunction

  wire altActive = jogActive || panelControl;
  logic signed [15:0] mainWord, mainScale, suppWord, suppScale;

  // Picks read module state inside the functions, so a process keeps them fresh
  always_comb
  begin
    mainWord = altActive ? altSetpoint : pickWord(mainSrc);
    mainScale = pickWord(mainScaleSrc);
    suppWord = pickWord(suppSrc);
    suppScale = pickWord(suppScaleSrc);
    potBus.setValue = pickWord(setValSrc);
    potBus.raise = pickBit(raiseSrc);
    potBus.lower = pickBit(lowerSrc);
    potBus.accept = pickBit(acceptSrc);
  end
  wire signed [31:0] mainProd = mainWord * mainScale;
  wire signed [31:0] suppProd = suppWord * suppScale;
  wire signed [32:0] prodSum = 33'(mainProd) + 33'(suppProd);
  wire signed [32:0] scaled = prodSum >>> SCALE_SHIFT;
  wire satHigh = scaled > 33'sh0_0000_7fff;
  wire satLow = scaled < -33'sh0_0000_8000;
  wire signed [15:0] satSum = satHigh ? 16'sh7fff : satLow ? 16'sh8000 : scaled[15:0];
  wire signed [15:0] next_total = positionerActive ? 16'sh0000 : satSum;

  assign potBus.startValue = startValue;
  assign potBus.maxSpeed = maxSpeed;
  assign potBus.minSpeed = minSpeed;
  assign potBus.refMax = refMax;
  assign potBus.riseMs = riseMs;
  assign potBus.fallMs = fallMs;
  assign potBus.cfg = potCfg;
  assign potBus.motorOn = motorOn;
  assign potBus.msTick = msTick;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      totalSetpoint <= 16'sh0000;
      activeMainSetpoint <= 16'sh0000;
      potRampedOutput <= RST_START;
    end
    else
    begin
      totalSetpoint <= next_total;
      activeMainSetpoint <= mainWord;
      potRampedOutput <= potBus.outValue;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Ramp tick prescaler
  wire tickWrap = tickCnt == 16'(TICK_CYCLES - 1);
  wire [15:0] next_tickCnt = tickWrap ? 16'h0000 : tickCnt + 16'h0001;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tickCnt <= 16'h0000;
      msTick <= 1'b0;
    end
    else
    begin
      tickCnt <= next_tickCnt;
      msTick <= tickWrap;
    end
  end

  ////////////////////////////////////////////////////////////////
  // AHB-Lite slave
  wire busReq = hsel && htrans[1] && hready;
  wire next_ready = !(busReq && !hwrite);
  wire [3:0] rdIdx = rdAddr[5:2];
  wire [3:0] wrIdx = wrAddr[5:2];

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wrPend <= 1'b0;
      rdPend <= 1'b0;
      wrAddr <= 8'h00;
      rdAddr <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
    end
    else
    begin
      wrPend <= busReq && hwrite && hsize == SIZE_WORD;
      rdPend <= busReq && !hwrite;
      if (busReq)
      begin
        wrAddr <= haddr[7:0];
        rdAddr <= haddr[7:0];
      end
      hreadyout <= next_ready;
      hresp <= 1'b0;
      if (rdPend)
        hrdata <= rdValue;
    end
  end

  always_comb
  begin
    rdValue = 32'h0000_0000;
    case (rdAddr)
      A_MAIN_SRC: rdValue = {24'h0, mainSrc};
      A_MSCALE_SRC: rdValue = {24'h0, mainScaleSrc};
      A_SUPP_SRC: rdValue = {24'h0, suppSrc};
      A_SSCALE_SRC: rdValue = {24'h0, suppScaleSrc};
      A_RAISE_SRC: rdValue = {24'h0, raiseSrc};
      A_LOWER_SRC: rdValue = {24'h0, lowerSrc};
      A_ACCEPT_SRC: rdValue = {24'h0, acceptSrc};
      A_SETVAL_SRC: rdValue = {24'h0, setValSrc};
      A_START: rdValue = {16'h0, startValue};
      A_RISE_MS: rdValue = {16'h0, riseMs};
      A_FALL_MS: rdValue = {16'h0, fallMs};
      A_MAX: rdValue = {16'h0, maxSpeed};
      A_MIN: rdValue = {16'h0, minSpeed};
      A_CFG: rdValue = {27'h0, potCfg};
      A_REF_MAX: rdValue = {16'h0, refMax};
      A_ACTIVE_MAIN: rdValue = {16'h0, activeMainSetpoint};
      A_POT_OUT: rdValue = {16'h0, potRampedOutput};
      A_TOTAL: rdValue = {16'h0, totalSetpoint};
      default:
      begin
        if (rdAddr[7:6] == A_RX_BASE[7:6] && rdAddr[1:0] == 2'b00 && int'(rdIdx) < RX_WORDS)
          rdValue = {16'h0, fieldbusReceiveWords[int'(rdIdx)*16 +: 16]};
        else if (rdAddr[7:4] == A_FIX_BASE[7:4] && rdAddr[1:0] == 2'b00)
          rdValue = {16'h0, fixedSp[rdIdx[1:0]]};
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mainSrc <= HAS_FIELDBUS ? RST_MAIN_SRC_FB : RST_MAIN_SRC_NOFB;
      mainScaleSrc <= RST_MSCALE_SRC;
      suppSrc <= RST_SUPP_SRC;
      suppScaleSrc <= RST_SSCALE_SRC;
      raiseSrc <= HAS_FIELDBUS ? RST_RAISE_FB : RST_BIN_ZERO;
      lowerSrc <= HAS_FIELDBUS ? RST_LOWER_FB : RST_BIN_ZERO;
      acceptSrc <= RST_BIN_ZERO;
      setValSrc <= SRC_ZERO;
      startValue <= RST_START;
      riseMs <= RST_RAMP_MS;
      fallMs <= RST_RAMP_MS;
      maxSpeed <= RST_POT_LIMIT;
      minSpeed <= RST_POT_LIMIT;
      potCfg <= RST_POT_CFG;
      refMax <= RST_REF_MAX;
    end
    else if (wrPend)
    begin
      case (wrAddr)
        A_MAIN_SRC: mainSrc <= hwdata[7:0];
        A_MSCALE_SRC: mainScaleSrc <= hwdata[7:0];
        A_SUPP_SRC: suppSrc <= hwdata[7:0];
        A_SSCALE_SRC: suppScaleSrc <= hwdata[7:0];
        A_RAISE_SRC: raiseSrc <= hwdata[7:0];
        A_LOWER_SRC: lowerSrc <= hwdata[7:0];
        A_ACCEPT_SRC: acceptSrc <= hwdata[7:0];
        A_SETVAL_SRC: setValSrc <= hwdata[7:0];
        A_START: startValue <= hwdata[15:0];
        A_RISE_MS: riseMs <= hwdata[15:0];
        A_FALL_MS: fallMs <= hwdata[15:0];
        A_MAX: maxSpeed <= hwdata[15:0];
        A_MIN: minSpeed <= hwdata[15:0];
        A_CFG: potCfg <= hwdata[4:0];
        A_REF_MAX: refMax <= hwdata[15:0];
        default: mainSrc <= mainSrc;
      endcase
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < FIX_WORDS; gi++)
    begin : g_fix
      always_ff @(posedge clk or negedge arst_n)
      begin
        if (!arst_n)
          fixedSp[gi] <= RST_FIXED;
        else if (wrPend && wrAddr[7:4] == A_FIX_BASE[7:4] && int'(wrIdx) == gi)
          fixedSp[gi] <= hwdata[15:0];
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence readWait;
    !hreadyout ##1 hreadyout;
  endsequence
  chk_pos_zero: assert property (positionerActive |=> totalSetpoint == 16'sh0000)
    else $error("setpoint not zero under positioner");
  chk_alt_main: assert property (altActive |=> activeMainSetpoint == $past(altSetpoint))
    else $error("alternative setpoint not applied");
  chk_word_one: assert property (!altActive && mainSrc == SRC_RX_BASE + 8'h01 |=>
    activeMainSetpoint == $past(fieldbusReceiveWords[31:16]))
    else $error("second receive word not selected");
  chk_total_sum: assert property (!positionerActive && !satHigh && !satLow |=>
    totalSetpoint == $past(scaled[15:0]))
    else $error("total setpoint mismatch");
  chk_pot_route: assert property (!altActive && mainSrc == SRC_POT |=>
    activeMainSetpoint == potRampedOutput)
    else $error("pot output not routed to main");
  chk_read_wait: assert property (busReq && !hwrite |=> readWait)
    else $error("read wait state wrong");
endmodule

// >>> dv/sspc_fb_model.sv
// Purpose: Fieldbus controller model feeding receive and control words
// Assumes: Same clock as the channel
// Notes: Bench loads one receive word per strobe
`timescale 1ns/1ps
module sspc_fb_model
  import sspc_pkg::*;
(
  input wire logic clk, // Control clock
  input wire logic arst_n, // Async reset, active low
  input wire logic wordStb, // Load one word
  input wire logic [3:0] wordIdx, // Word index
  input wire logic [15:0] wordVal, // Word value
  input wire logic [15:0] ctrlVal, // Next control word
  output logic [RX_WORDS*16-1:0] rxWords, // Receive words
  output logic [15:0] ctrlWord // Control word bits
);
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rxWords <= '0;
      ctrlWord <= 16'h0000;
    end
    else
    begin
      if (wordStb)
        rxWords[wordIdx*16 +: 16] <= wordVal;
      ctrlWord <= ctrlVal;
    end
  end
endmodule

// >>> dv/tb_top.sv
// Purpose: Self-checking bench of the speed setpoint channel
// Assumes: All results are read back over the bus
// Notes: Ramp tick shortened to 4 cycles
`timescale 1ns/1ps
module tb_top
  import sspc_pkg::*;
;
  logic clk, arst_n, hsel, hwrite, hreadyout, hresp, wordStb, pend;
  logic jogActive, panelControl, positionerActive, motorOn;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] wordIdx;
  logic [15:0] wordVal, ctrlVal, ctrlWord, w1, w2;
  logic [RX_WORDS*16-1:0] rxWords;
  logic signed [15:0] analogIn, altSetpoint, totalSetpoint, activeMainSetpoint, potRampedOutput;
  logic [31:0] expQ[$];
  int error_cnt, checks_done;
  sspc_channel #(.HAS_FIELDBUS(1'b1), .TICK_CYCLES(4)) sspc_channel_i (.clk(clk),
    .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .fieldbusReceiveWords(rxWords),
    .fieldbusControlWordBits(ctrlWord), .analogIn(analogIn), .altSetpoint(altSetpoint),
    .jogActive(jogActive), .panelControl(panelControl), .positionerActive(positionerActive),
    .motorOn(motorOn), .totalSetpoint(totalSetpoint), .activeMainSetpoint(activeMainSetpoint),
    .potRampedOutput(potRampedOutput));
  sspc_fb_model sspc_fb_model_i (.clk(clk), .arst_n(arst_n), .wordStb(wordStb),
    .wordIdx(wordIdx), .wordVal(wordVal), .ctrlVal(ctrlVal), .rxWords(rxWords),
    .ctrlWord(ctrlWord));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    if (error_cnt == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic cmp_read(input logic [32:0] act, input logic [32:0] exp);
    checks_done++;
    if (act !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t read %h expected %h", $time, act, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (!hreadyout);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (!hreadyout);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    expQ.push_back({16'h0, e});
    xfer(1'b0, a, 32'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    xfer(1'b1, a, {16'h0, d});
  endtask
  task automatic idle(input int c);
    repeat (c) @(posedge clk);
  endtask
  task automatic setw(input logic [3:0] i, input logic [15:0] v);
    wordIdx <= i;
    wordVal <= v;
    wordStb <= 1'b1;
    @(posedge clk);
    wordStb <= 1'b0;
    @(posedge clk);
  endtask
  // Read data checked when the data phase completes
  always @(posedge clk)
  begin
    if (pend && hreadyout)
    begin
      pend = 1'b0;
      cmp_read({hresp, hrdata}, {1'b0, expQ.pop_front()});
    end
    if (hsel && htrans[1] && hreadyout && !hwrite)
      pend = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    static logic [7:0] ra[12] = '{A_MAIN_SRC, A_MSCALE_SRC, A_SUPP_SRC, A_SSCALE_SRC, A_RAISE_SRC,
      A_LOWER_SRC, A_START, A_RISE_MS, A_FALL_MS, A_MAX, A_MIN, A_CFG};
    static logic [15:0] rv[12] = '{16'h0011, 16'h0001, 16'h0000, 16'h0000, 16'h002d, 16'h002e,
      16'h0000, 16'h2710, 16'h2710, 16'h0000, 16'h0000, 16'h0006};
    void'($urandom(7));
    {hsel, hsize, htrans, haddr, hwrite, hwdata} = {1'b1, 3'h2, 2'h0, 32'h0, 1'b0, 32'h0};
    {wordStb, wordIdx, wordVal, ctrlVal, pend, motorOn} = '0;
    {jogActive, panelControl, positionerActive, altSetpoint} = '0;
    analogIn = 16'($urandom_range(8000) - 4000);
    w1 = 16'($urandom_range(8000) - 4000);
    w2 = 16'($urandom_range(8000) - 4000);
    error_cnt = 0;
    checks_done = 0;
    arst_n = 1'b0;
    idle(6);
    arst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 12; i++)
      rd(ra[i], rv[i]);
    rd(8'h3c, 16'h0000);
    wr(A_ACTIVE_MAIN, 16'h1234);
    setw(4'h1, w1);
    setw(4'h2, w2);
    rd(A_RX_BASE + 8'h04, w1);
    rd(A_ACTIVE_MAIN, w1);
    rd(A_TOTAL, w1);
    wr(A_SUPP_SRC, 16'h0012);
    wr(A_SSCALE_SRC, 16'h0001);
    idle(2);
    rd(A_TOTAL, w1 + w2);
    positionerActive <= 1'b1;
    idle(2);
    rd(A_TOTAL, 16'h0000);
    positionerActive <= 1'b0;
    altSetpoint <= w2;
    jogActive <= 1'b1;
    idle(2);
    rd(A_ACTIVE_MAIN, w2);
    jogActive <= 1'b0;
    panelControl <= 1'b1;
    idle(2);
    rd(A_ACTIVE_MAIN, w2);
    panelControl <= 1'b0;
    wr(A_FIX_BASE + 8'h04, 16'h0123);
    wr(A_MAIN_SRC, 16'h0031);
    idle(2);
    rd(A_ACTIVE_MAIN, 16'h0123);
    wr(A_MAIN_SRC, 16'h0040);
    idle(2);
    rd(A_ACTIVE_MAIN, analogIn);
    wr(A_MAX, 16'd100);
    wr(A_MIN, 16'hffce);
    wr(A_RISE_MS, 16'h0001);
    wr(A_FALL_MS, 16'h0001);
    wr(A_REF_MAX, 16'h0001);
    wr(A_MAIN_SRC, 16'h0020);
    motorOn <= 1'b1;
    ctrlVal <= 16'h2000;
    idle(600);
    rd(A_POT_OUT, 16'd100);
    rd(A_ACTIVE_MAIN, 16'd100);
    ctrlVal <= 16'h4000;
    idle(800);
    rd(A_POT_OUT, 16'hffce);
    wr(A_FIX_BASE, 16'h002a);
    wr(A_SETVAL_SRC, 16'h0030);
    wr(A_ACCEPT_SRC, 16'h0020);
    ctrlVal <= 16'h0001;
    idle(4);
    rd(A_POT_OUT, 16'h002a);
    wr(A_START, 16'h000a);
    for (int k = 0; k < 2; k++)
    begin
      wr(A_CFG, k ? 16'h0006 : 16'h0007);
      motorOn <= 1'b0;
      idle(4);
      // Move the pot while off, so a restore is told apart from a held value
      ctrlVal <= 16'h0000;
      wr(A_SETVAL_SRC, 16'h0000);
      ctrlVal <= 16'h0001;
      idle(4);
      motorOn <= 1'b1;
      idle(4);
      rd(A_POT_OUT, k ? 16'h000a : 16'h002a);
    end
    tally_and_finish();
  end
  initial
  begin
    #(40 * 10000);
    error_cnt++;
    tally_and_finish();
  end
endmodule
